// [logic/frc_pkg.sv]
// constants and types shared by the free-running counter core
package frc_pkg;
  localparam int          COUNT_W        = 16;
  localparam logic [15:0] COUNT_RST      = 16'hFFFC;  // count after reset
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  // clock_select field encodings
  localparam logic [1:0]  CLK_SEL_DIV4   = 2'h0;
  localparam logic [1:0]  CLK_SEL_DIV2   = 2'h1;
  localparam logic [1:0]  CLK_SEL_DIV8   = 2'h2;
  localparam logic [1:0]  CLK_SEL_EXT    = 2'h3;
  // prescaler divide ratios, minus one
  localparam logic [2:0]  PRESC2_LAST    = 3'h1;
  localparam logic [2:0]  PRESC4_LAST    = 3'h3;
  localparam logic [2:0]  PRESC8_LAST    = 3'h7;
  // least cpu-clock spacing between external active edges
  localparam int          EXT_MIN_GAP    = 4;
  // two-byte read sequence states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_HELD = 2'b10
  } read_state_type;
endpackage : frc_pkg

// [logic/frc_tick_if.sv]
// interface carrying the count tick between the tick source and the core
`timescale 1ns/1ps
interface frc_tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface : frc_tick_if

// [logic/frc_tick_gen.sv]
// tick generator: prescaler or synchronised external clock edge detector
`timescale 1ns/1ps
module frc_tick_gen
  import frc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] clock_select_i,
  input  wire logic       ext_clock_edge_select_i,
  input  wire logic       ext_count_clock_pin_i,
  frc_tick_if.source      tk
);
  logic [2:0] presc_r;
  logic [2:0] presc_last;
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic       tick_r;
  logic       ext_mode;
  logic       presc_wrap;
  logic       ext_edge;

  // prescale ratio selection [RQ14]
  assign presc_last = (clock_select_i == CLK_SEL_DIV2) ? PRESC2_LAST :
                      (clock_select_i == CLK_SEL_DIV8) ? PRESC8_LAST : PRESC4_LAST;
  assign ext_mode   = (clock_select_i == CLK_SEL_EXT);             // [RQ10]
  assign presc_wrap = (presc_r >= presc_last);
  // rising when select is one, falling when zero [RQ11]
  assign ext_edge   = ext_clock_edge_select_i ? (sync2_r & ~prev_r) : (~sync2_r & prev_r);

  // two-stage synchroniser, edge history reads only the second stage [RQ15]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= ext_count_clock_pin_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // prescaler holds while halted so a wake resumes mid-period
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= 3'h0;
    end else if (run_i) begin
      presc_r <= presc_wrap ? 3'h0 : presc_r + 3'h1;               // [RQ14]
    end
  end

  // one tick per period or per active edge, registered on the cpu clock [RQ12]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= run_i & (ext_mode ? ext_edge : presc_wrap);        // [RQ15] [RQ16]
    end
  end

  assign tk.tick = tick_r;
endmodule : frc_tick_gen

// [logic/free_running_counter_core.sv]
// free-running 16-bit counter core with buffered two-byte read and overflow flag
// Overview of operation
// RQ1 - high byte read first captures low byte
// RQ2 - held low byte frozen until sequence ends
// RQ3 - lone low byte read returns live count
// RQ4 - wrap to zero sets overflow flag
// RQ5 - interrupt only if enabled and unmasked
// RQ6 - flag cleared by status read then low access
// RQ7 - alternate low byte access never clears flag
// RQ8 - counter keeps running in wait mode
// RQ9 - halt freezes count, reset restarts it
// RQ10 - both select bits one picks external clock
// RQ11 - edge select picks rising or falling edge
// RQ12 - all updates synchronous to cpu clock
// RQ13 - external edges at least four cpu clocks apart
// RQ14 - internal clock divided by 2, 4 or 8
// RQ15 - external pin synchronised, one count per edge
// RQ16 - one count per tick, wraps modulo 65536
`timescale 1ns/1ps
module free_running_counter_core
  import frc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       halt_i,
  input  wire logic       wait_i,
  input  wire logic [1:0] clock_select_i,
  input  wire logic       ext_clock_edge_select_i,
  input  wire logic       overflow_irq_enable_i,
  input  wire logic       irq_mask_i,
  input  wire logic       ext_count_clock_pin_i,
  input  wire logic       rd_high_i,
  input  wire logic       rd_low_i,
  input  wire logic       rd_alt_high_i,
  input  wire logic       rd_alt_low_i,
  input  wire logic       acc_low_i,
  input  wire logic       rd_status_i,
  output logic [7:0]      rd_data_o,
  output logic            overflow_flag_o,
  output logic            irq_o,
  output logic [15:0]     count_o
);
  frc_tick_if tk ();

  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [7:0]     held_low_r;
  logic [7:0]     rd_data_r;
  logic [7:0]     rd_data_nxt;
  logic           flag_r;
  logic           flag_nxt;
  logic           armed_r;
  logic           irq_r;
  read_state_type rd_state_r;
  read_state_type rd_state_nxt;
  logic           run;
  logic           wrap;
  logic           any_high;
  logic           any_low;
  logic           clr_done;

  // wait mode does not gate the count, only halt does [RQ8] [RQ9]
  assign run = ~halt_i;

  frc_tick_gen u_tick (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (rst_i),
    .run_i                   (run),
    .clock_select_i          (clock_select_i),
    .ext_clock_edge_select_i (ext_clock_edge_select_i),
    .ext_count_clock_pin_i   (ext_count_clock_pin_i),
    .tk                      (tk.source)
  );

  // count advance and wrap detection [RQ16]
  assign count_nxt = tk.tick ? count_r + 16'h0001 : count_r;
  assign wrap      = tk.tick & (count_r == COUNT_MAX);              // [RQ4]

  // read strobes of both counter views
  assign any_high  = rd_high_i | rd_alt_high_i;
  assign any_low   = rd_low_i | rd_alt_low_i;

  // only the main low byte finishes the clear; alternate view excluded [RQ6] [RQ7]
  assign clr_done  = armed_r & acc_low_i;
  // a wrap in the clearing cycle wins over the clear
  assign flag_nxt  = wrap | (flag_r & ~clr_done);                   // [RQ4] [RQ6]

  // read sequencer: high read captures, low read completes [RQ1] [RQ2]
  always_comb begin
    rd_state_nxt = rd_state_r;
    if (any_high) begin
      rd_state_nxt = RD_HELD;
    end else if (any_low) begin
      rd_state_nxt = RD_IDLE;
    end
  end

  // read data mux: held byte inside a sequence, live byte otherwise [RQ3]
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (any_high) begin
      rd_data_nxt = count_r[15:8];
    end else if (any_low) begin
      rd_data_nxt = (rd_state_r == RD_HELD) ? held_low_r : count_r[7:0];
    end else if (rd_status_i) begin
      rd_data_nxt = {7'h00, flag_r};
    end
  end

  // counter and flags; reset restarts the count from its reset value [RQ9] [RQ12]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= COUNT_RST;
      flag_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      flag_r  <= flag_nxt;
    end
  end

  // status read while flag set arms the second clear step [RQ6]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else if (clr_done | wrap) begin
      armed_r <= 1'b0;
    end else if (rd_status_i & flag_r) begin
      armed_r <= 1'b1;
    end
  end

  // capture only on the first high read; repeated high reads keep it [RQ1] [RQ2]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_low_r <= 8'h00;
    end else if (any_high & (rd_state_r == RD_IDLE)) begin
      held_low_r <= count_r[7:0];
    end
  end

  // read path registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state_r <= RD_IDLE;
      rd_data_r  <= 8'h00;
    end else begin
      rd_state_r <= rd_state_nxt;
      rd_data_r  <= rd_data_nxt;
    end
  end

  // pending request is shown only while enabled and unmasked [RQ5]
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_nxt & overflow_irq_enable_i & ~irq_mask_i;
    end
  end

  assign rd_data_o       = rd_data_r;
  assign overflow_flag_o = flag_r;
  assign irq_o           = irq_r;
  assign count_o         = count_r;
endmodule : free_running_counter_core

// [tb/frc_sva.sv]
// concurrent checks on the counter core ports
`timescale 1ns/1ps
module frc_sva
  import frc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        halt_i,
  input wire logic        overflow_irq_enable_i,
  input wire logic        irq_mask_i,
  input wire logic        rd_high_i,
  input wire logic        acc_low_i,
  input wire logic        rd_status_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        overflow_flag_o,
  input wire logic        irq_o,
  input wire logic [15:0] count_o
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_wrap_sets_flag: assert property (
    $past(count_o) == COUNT_MAX && count_o == 16'h0000 |-> overflow_flag_o)
    else $error("flag not set on wrap");
  a_count_steps_one: assert property (
    !$stable(count_o) |-> count_o == $past(count_o) + 16'h0001)
    else $error("count moved by other than one");
  a_halt_freezes: assert property (
    $past(halt_i) && $past(halt_i, 2) |-> $stable(count_o))
    else $error("count moved in halt");
  a_irq_gated: assert property (
    irq_o |-> overflow_flag_o && $past(overflow_irq_enable_i) && !$past(irq_mask_i))
    else $error("interrupt without cause");
  a_irq_raised: assert property (
    overflow_flag_o && $past(overflow_irq_enable_i) && !$past(irq_mask_i) |-> irq_o)
    else $error("pending interrupt not raised");
  a_flag_holds: assert property (
    overflow_flag_o && !acc_low_i |=> overflow_flag_o)
    else $error("flag cleared without low access");
  a_flag_clears: assert property (
    rd_status_i && overflow_flag_o ##[1:4] (acc_low_i && count_o != COUNT_MAX)
    |=> !overflow_flag_o) else $error("flag not cleared");
  a_high_read: assert property (
    rd_high_i |=> rd_data_o == 8'($past(count_o) >> 8))
    else $error("high byte read wrong");
endmodule : frc_sva

// [tb/tb.sv]
// self-checking bench for the counter core
`timescale 1ns/1ps
module tb import frc_pkg::*;;
  logic        sys_clk_i, rst_i, halt_i, wait_i, ext_clock_edge_select_i, irq_o;
  logic        overflow_irq_enable_i, irq_mask_i, ext_count_clock_pin_i, rd_alt_high_i;
  logic        rd_high_i, rd_low_i, rd_alt_low_i, acc_low_i, rd_status_i, overflow_flag_o;
  logic [1:0]  clock_select_i;
  logic [5:0]  strb;
  logic [7:0]  rd_data_o, d;
  logic [15:0] count_o, cs, s, h;
  int          error_cnt = 0, total_checks = 0, n;
  free_running_counter_core DUT (.*);
  // strobe codes: alt high, high, low, alt low, low access, status
  assign {rd_alt_high_i, rd_high_i, rd_low_i, rd_alt_low_i, acc_low_i, rd_status_i} = strb;
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask : cyc
  // one read strobe; cs is the count the core sees at the strobe edge
  task automatic rd(input logic [5:0] m);
    @(posedge sys_clk_i) strb <= m;
    @(negedge sys_clk_i) cs = count_o;
    @(posedge sys_clk_i) strb <= 6'h00;
    #1 d = rd_data_o;
  endtask : rd
  // cycles until the count next moves, bounded so a stuck count cannot hang
  task automatic wchg();
    s = count_o;
    n = 0;
    while (count_o === s && n < 100) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (n == 100) begin
      error_cnt++;
      end_sim();
    end
  endtask : wchg
  task automatic per(input logic [1:0] sl, input logic [2:0] last);
    @(posedge sys_clk_i) clock_select_i <= sl;
    wchg();
    wchg();
    chk(16'(n), 16'(last) + 16'h0001);
  endtask : per
  initial begin
    {rst_i, halt_i, wait_i, ext_clock_edge_select_i, ext_count_clock_pin_i} = 5'h10;
    {overflow_irq_enable_i, irq_mask_i, strb} = 8'hC0;
    clock_select_i = CLK_SEL_DIV2;
    cyc(2);
    chk(count_o, COUNT_RST);
    rst_i <= 1'b0;
    // first wrap arrives masked, so the request must stay pending
    cyc(20);
    chk(16'(overflow_flag_o), 16'h0001);
    chk(16'(irq_o), 16'h0000);
    rd(5'h02);
    chk(16'(overflow_flag_o), 16'h0001);
    irq_mask_i <= 1'b0;
    cyc(2);
    chk(16'(irq_o), 16'h0001);
    // enable gates the pending request too
    overflow_irq_enable_i <= 1'b0;
    cyc(2);
    chk(16'(irq_o), 16'h0000);
    overflow_irq_enable_i <= 1'b1;
    cyc(2);
    chk(16'(irq_o), 16'h0001);
    rd(5'h01);
    chk(16'(d), 16'h0001);
    rd(5'h04);
    chk(16'(overflow_flag_o), 16'h0001);
    rd(5'h0A);
    chk(16'(overflow_flag_o), 16'h0000);
    chk(16'(irq_o), 16'h0000);
    // slow count so the low byte moves while a sequence is open
    clock_select_i <= CLK_SEL_DIV8;
    rd(5'h10);
    chk(16'(d), 16'(cs[15:8]));
    h = cs;
    cyc(40);
    rd(5'h10);
    cyc(40);
    rd(5'h0A);
    chk(16'(d), 16'(h[7:0]));
    rd(5'h04);
    chk(16'(d), 16'(cs[7:0]));
    rd(5'h10);
    h = cs;
    cyc(40);
    rd(5'h04);
    chk(16'(d), 16'(h[7:0]));
    rd(5'h0A);
    chk(16'(d), 16'(cs[7:0]));
    // alternate high read opens a sequence just as the main one does
    rd(6'h20);
    chk(16'(d), 16'(cs[15:8]));
    h = cs;
    cyc(40);
    rd(6'h0A);
    chk(16'(d), 16'(h[7:0]));
    // wait mode stays on while the tick rates are measured
    wait_i <= 1'b1;
    per(CLK_SEL_DIV2, PRESC2_LAST);
    per(CLK_SEL_DIV4, PRESC4_LAST);
    per(CLK_SEL_DIV8, PRESC8_LAST);
    @(posedge sys_clk_i) halt_i <= 1'b1;
    cyc(2);
    #1 h = count_o;
    cyc(30);
    chk(count_o, h);
    halt_i <= 1'b0;
    wchg();
    chk(count_o, h + 16'h0001);
    // pin edges six cycles apart, each edge select in turn
    clock_select_i <= CLK_SEL_EXT;
    for (int e = 1; e >= 0; e--) begin
      ext_clock_edge_select_i <= e[0];
      cyc(8);
      @(negedge sys_clk_i) h = count_o;
      @(posedge sys_clk_i) ext_count_clock_pin_i <= 1'b1;
      cyc(EXT_MIN_GAP + 2);
      chk(count_o, h + 16'(e));
      ext_count_clock_pin_i <= 1'b0;
      cyc(EXT_MIN_GAP + 2);
      chk(count_o, h + 16'h0001);
    end
    rst_i <= 1'b1;
    cyc(2);
    chk(count_o, COUNT_RST);
    end_sim();
  end
endmodule : tb
bind free_running_counter_core frc_sva chk (.*);
